// ===== dv/ncr_config_bank_tb.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module ncr_config_bank_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  ncr_pkg::ncr_req_t req = '0;
  logic [1:0] eepromModeSelect = 2'h0;
  logic eepromLoad = 1'b0;
  logic [7:0] eepromIrqIo = 8'h80;
  logic [7:0] eepromMedBoot = 8'h00;
  logic [7:0] eepromLedPwr = 8'h01;
  logic jumperModeInput = 1'b0;
  logic pnpJumperPin = 1'b0;
  logic attachmentUnitIn = 1'b0;
  logic linkTestFail = 1'b0;
  logic activateBit0 = 1'b1;
  logic irqReq = 1'b1;
  logic [7:0] rdata;
  logic [7:0] intOut;
  logic [7:0] intOe_n;
  logic sleepMode;
  logic powerdownClkRun;
  logic powerdownClkHalt;
  int mismatches = 0;
  int samplesChecked = 0;
  int cycles = 0;

  ncr_config_bank #(.VARIANT(ncr_pkg::NCR_VER_WRITABLE)) dut_u (
    .clk, .sys_rst, .req, .eepromModeSelect, .eepromLoad, .eepromIrqIo, .eepromMedBoot,
    .eepromLedPwr, .jumperModeInput, .pnpJumperPin, .attachmentUnitIn, .linkTestFail,
    .activateBit0, .irqReq, .rdata, .intOut, .intOe_n, .sleepMode, .powerdownClkRun,
    .powerdownClkHalt
  );

  initial begin
    forever #5 clk = ~clk;
  end

  // whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // an idle cycle after each access keeps req to one assignment per time step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    req = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wdata: d};
    tick();
    req = '0;
    tick();
  endtask : wr

  task automatic rc(input logic [3:0] a, input logic [7:0] exp);
    req = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wdata: 8'h00};
    tick();
    req = '0;
    chk(rdata, exp);
    tick();
  endtask : rc

  task automatic ld(input logic [7:0] irqIo, input logic [7:0] ledPwr);
    eepromIrqIo = irqIo;
    eepromLedPwr = ledPwr;
    eepromLoad = 1'b1;
    tick();
    eepromLoad = 1'b0;
    tick(3);
  endtask : ld

  task automatic t_reset();
    rc(ncr_pkg::OFF_IRQ_IOBASE, 8'h80);
    rc(ncr_pkg::OFF_MEDIUM_BOOT, 8'h00);
    rc(ncr_pkg::OFF_LED_POWER, 8'h00);
    rc(ncr_pkg::OFF_CHIP_MEDIA, 8'h00);
    chk({6'h0, powerdownClkRun, powerdownClkHalt}, 8'h00);
  endtask : t_reset

  task automatic t_status();
    jumperModeInput = 1'b1;
    pnpJumperPin = 1'b1;
    attachmentUnitIn = 1'b1;
    linkTestFail = 1'b1;
    rc(ncr_pkg::OFF_CHIP_MEDIA, 8'h3c);
    linkTestFail = 1'b0;
    activateBit0 = 1'b0;
    rc(ncr_pkg::OFF_CHIP_MEDIA, 8'h38);
    rc(ncr_pkg::OFF_LED_POWER, 8'h01);
  endtask : t_status

  task automatic t_masks();
    wr(ncr_pkg::OFF_IRQ_IOBASE, 8'h00);
    rc(ncr_pkg::OFF_IRQ_IOBASE, 8'h80);
    wr(ncr_pkg::OFF_CHIP_MEDIA, 8'hc0);
    rc(ncr_pkg::OFF_CHIP_MEDIA, 8'h38);
    eepromModeSelect = ncr_pkg::EEM_CFG_WRITE;
    wr(ncr_pkg::OFF_IRQ_IOBASE, 8'h7f);
    rc(ncr_pkg::OFF_IRQ_IOBASE, 8'h00);
    chk(intOe_n, 8'hff);
    wr(ncr_pkg::OFF_IRQ_IOBASE, 8'hff);
    rc(ncr_pkg::OFF_IRQ_IOBASE, 8'h80);
    wr(ncr_pkg::OFF_MEDIUM_BOOT, 8'hff);
    rc(ncr_pkg::OFF_MEDIUM_BOOT, 8'he0);
    rc(ncr_pkg::OFF_CHIP_MEDIA, 8'h3c);
    wr(ncr_pkg::OFF_CHIP_MEDIA, 8'h80);
    rc(ncr_pkg::OFF_CHIP_MEDIA, 8'hbc);
    wr(ncr_pkg::OFF_LED_POWER, 8'hf9);
    rc(ncr_pkg::OFF_LED_POWER, 8'h01);
    wr(ncr_pkg::OFF_LED_POWER, 8'hff);
    rc(ncr_pkg::OFF_LED_POWER, 8'h07);
    chk({7'h0, sleepMode}, 8'h01);
    eepromModeSelect = 2'h1;
    wr(ncr_pkg::OFF_LED_POWER, 8'h00);
    rc(ncr_pkg::OFF_LED_POWER, 8'h07);
  endtask : t_masks

  task automatic t_halt();
    ld(8'h80, 8'h01);
    wr(ncr_pkg::OFF_HALT_CLOCK, ncr_pkg::HALT_HALTED);
    chk({6'h0, powerdownClkRun, powerdownClkHalt}, 8'h00);
    ld(8'h80, 8'h02);
    rc(ncr_pkg::OFF_LED_POWER, 8'h03);
    wr(ncr_pkg::OFF_HALT_CLOCK, ncr_pkg::HALT_HALTED);
    tick();
    chk({6'h0, powerdownClkRun, powerdownClkHalt}, 8'h01);
    wr(ncr_pkg::OFF_HALT_CLOCK, 8'h33);
    tick();
    chk({6'h0, powerdownClkRun, powerdownClkHalt}, 8'h01);
    wr(ncr_pkg::OFF_HALT_CLOCK, ncr_pkg::HALT_RUNNING);
    tick();
    chk({6'h0, powerdownClkRun, powerdownClkHalt}, 8'h02);
  endtask : t_halt

  // every line select, each loaded with the output enable set
  task automatic t_irq();
    for (int s = 0; s < 8; s++) begin
      ld({1'b1, 3'(s), 4'h0}, 8'h00);
      chk(intOe_n, ~(8'h01 << s));
      chk({7'h0, intOut[s]}, 8'h01);
    end
  endtask : t_irq

  initial begin
    tick(12);
    sys_rst = 1'b0;
    tick();
    t_reset();
    t_status();
    t_masks();
    t_halt();
    t_irq();
    summarize();
  end
endmodule : ncr_config_bank_tb
`default_nettype wire

// ===== hw/ncr_config_bank.sv
// configuration register bank: chip/medium status, irq/io, medium/boot, led/power, halt clock
//
// Overview of operation
// - version clears at reset and is writable in config mode only in the writable variant; fixed variants reset to 11 or 10
// - version behaviour identifies the chip variant
// - jumper status bit mirrors the jumper input
// - coax flag: auto with link fail, or select 11
// - inactive flag is inverse of activate bit 0
// - irq/io register: only bit 7 writable
// - medium/boot register: only bits 7..5 writable
// - led/power register: only bits 2..1 writable
// - halt clock 52h runs, 48h halts, when powered down
`timescale 1ns/1ps
`default_nettype none
module ncr_config_bank #(
  parameter ncr_pkg::ncr_variant_t VARIANT = ncr_pkg::NCR_VER_WRITABLE
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire ncr_pkg::ncr_req_t req,
  input wire logic [1:0] eepromModeSelect,
  input wire logic eepromLoad,
  input wire logic [7:0] eepromIrqIo,
  input wire logic [7:0] eepromMedBoot,
  input wire logic [7:0] eepromLedPwr,
  input wire logic jumperModeInput,
  input wire logic pnpJumperPin,
  input wire logic attachmentUnitIn,
  input wire logic linkTestFail,
  input wire logic activateBit0,
  input wire logic irqReq,
  output logic [7:0] rdata,
  output logic [7:0] intOut,
  output logic [7:0] intOe_n,
  output logic sleepMode,
  output logic powerdownClkRun,
  output logic powerdownClkHalt
);
  ncr_pkg::ncr_state_t st;
  ncr_pkg::ncr_state_t next_st;
  logic cfgMode;
  logic [7:0] nxtIrqIo;
  logic [7:0] nxtMedBoot;
  logic [7:0] nxtLedPwr;
  logic [7:0] statusByte;
  logic coaxFlag;
  logic [7:0] routeOut;
  logic [7:0] routeOe_n;

  assign cfgMode = (eepromModeSelect == ncr_pkg::EEM_CFG_WRITE);

  ncr_masked_reg #(.MASK(ncr_pkg::MASK_IRQ_IOBASE)) uIrqIo (
    .cur(st.irqIo),
    .wdata(req.wdata),
    .we(req.wrEn && cfgMode && req.addr == ncr_pkg::OFF_IRQ_IOBASE),
    .nxt(nxtIrqIo)
  );
  ncr_masked_reg #(.MASK(ncr_pkg::MASK_MEDIUM_BOOT)) uMedBoot (
    .cur(st.medBoot),
    .wdata(req.wdata),
    .we(req.wrEn && cfgMode && req.addr == ncr_pkg::OFF_MEDIUM_BOOT),
    .nxt(nxtMedBoot)
  );
  ncr_masked_reg #(.MASK(ncr_pkg::MASK_LED_POWER)) uLedPwr (
    .cur(st.ledPwr),
    .wdata(req.wdata),
    .we(req.wrEn && cfgMode && req.addr == ncr_pkg::OFF_LED_POWER),
    .nxt(nxtLedPwr)
  );

  // medium select lives in bits 7..6 of the medium/boot register
  always_comb begin
    coaxFlag = (st.medBoot[7:6] == ncr_pkg::MEDIUM_COAX) ||
               ((st.medBoot[7:6] == ncr_pkg::MEDIUM_AUTO) && linkTestFail);
    statusByte = 8'h00;
    statusByte[ncr_pkg::POS_VERSION +: 2] = st.version;
    statusByte[ncr_pkg::POS_ATTACH] = attachmentUnitIn;
    statusByte[ncr_pkg::POS_PNP_JUMPER_FLAG] = pnpJumperPin;
    statusByte[ncr_pkg::POS_JUMPER] = jumperModeInput;
    statusByte[ncr_pkg::POS_COAX] = coaxFlag;
  end

  always_comb begin
    next_st = st;
    next_st.irqIo = nxtIrqIo;
    next_st.medBoot = nxtMedBoot;
    next_st.ledPwr = nxtLedPwr;
    // fixed variants keep their pattern; writable variant needs config mode
    if (VARIANT == ncr_pkg::NCR_VER_WRITABLE && req.wrEn && cfgMode &&
        req.addr == ncr_pkg::OFF_CHIP_MEDIA) begin
      next_st.version = req.wdata[ncr_pkg::POS_VERSION +: 2];
    end
    // eeprom autoload wins over a host write in the same cycle
    if (eepromLoad) begin
      next_st.irqIo = eepromIrqIo;
      next_st.medBoot = eepromMedBoot;
      next_st.ledPwr = eepromLedPwr;
    end
    if (!st.ledPwr[ncr_pkg::POS_POWERDOWN_ENABLE]) begin
      next_st.pdMode = ncr_pkg::NCR_PD_NONE;
    end else if (req.wrEn && req.addr == ncr_pkg::OFF_HALT_CLOCK) begin
      if (req.wdata == ncr_pkg::HALT_RUNNING) begin
        next_st.pdMode = ncr_pkg::NCR_PD_CLK_RUN;
      end else if (req.wdata == ncr_pkg::HALT_HALTED) begin
        next_st.pdMode = ncr_pkg::NCR_PD_CLK_HALT;
      end
    end
    next_st.rdata = 8'h00;
    if (req.rdEn) begin
      if (req.addr == ncr_pkg::OFF_CHIP_MEDIA) begin
        next_st.rdata = statusByte;
      end else if (req.addr == ncr_pkg::OFF_IRQ_IOBASE) begin
        next_st.rdata = st.irqIo;
      end else if (req.addr == ncr_pkg::OFF_MEDIUM_BOOT) begin
        next_st.rdata = st.medBoot;
      end else if (req.addr == ncr_pkg::OFF_LED_POWER) begin
        next_st.rdata = {st.ledPwr[7:1], ~activateBit0};
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st.version <= (VARIANT == ncr_pkg::NCR_VER_FIXED_11) ? 2'h3 :
                    (VARIANT == ncr_pkg::NCR_VER_FIXED_10) ? 2'h2 : ncr_pkg::VERSION_RESET;
      st.irqIo <= ncr_pkg::IRQ_IOBASE_RESET;
      st.medBoot <= ncr_pkg::MEDIUM_BOOT_RESET;
      st.ledPwr <= ncr_pkg::LED_POWER_RESET;
      st.pdMode <= ncr_pkg::NCR_PD_NONE;
      st.rdata <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  ncr_irq_route uRoute (
    .irqReq(irqReq),
    .enable(st.irqIo[ncr_pkg::POS_INTERRUPT_OUTPUT_ENABLE]),
    .lineSel(st.irqIo[6:4]),
    .intOut(routeOut),
    .intOe_n(routeOe_n)
  );

  // outputs registered once more so every port comes from a flip-flop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      intOut <= 8'h00;
      intOe_n <= 8'hff;
      sleepMode <= 1'b0;
      powerdownClkRun <= 1'b0;
      powerdownClkHalt <= 1'b0;
    end else begin
      intOut <= routeOut;
      intOe_n <= routeOe_n;
      sleepMode <= st.ledPwr[ncr_pkg::POS_SLEEP];
      powerdownClkRun <= (st.pdMode == ncr_pkg::NCR_PD_CLK_RUN);
      powerdownClkHalt <= (st.pdMode == ncr_pkg::NCR_PD_CLK_HALT);
    end
  end
  assign rdata = st.rdata;

  a_ro_irqio: assert property (@(posedge clk) disable iff (sys_rst)
    !eepromLoad |=> st.irqIo[6:0] == $past(st.irqIo[6:0])) else $error("irq/io low bits changed");
  a_ro_medboot: assert property (@(posedge clk) disable iff (sys_rst)
    !eepromLoad |=> st.medBoot[4:0] == $past(st.medBoot[4:0])) else $error("medium/boot low bits changed");
  a_ro_ledpwr: assert property (@(posedge clk) disable iff (sys_rst)
    !eepromLoad |=> {st.ledPwr[7:3], st.ledPwr[0]} == $past({st.ledPwr[7:3], st.ledPwr[0]}))
    else $error("led/power read-only bits changed");
  a_no_cfg_write: assert property (@(posedge clk) disable iff (sys_rst)
    !cfgMode && !eepromLoad |=> $stable(st.ledPwr) && $stable(st.irqIo) && $stable(st.medBoot))
    else $error("write taken outside config mode");
  a_powerdown_enable_write: assert property (@(posedge clk) disable iff (sys_rst)
    req.wrEn && cfgMode && !eepromLoad && req.addr == ncr_pkg::OFF_LED_POWER
    |=> st.ledPwr[ncr_pkg::POS_POWERDOWN_ENABLE] == $past(req.wdata[ncr_pkg::POS_POWERDOWN_ENABLE]))
    else $error("power-down bit write lost");
  a_version_lock: assert property (@(posedge clk) disable iff (sys_rst)
    !cfgMode |=> $stable(st.version)) else $error("version changed outside config mode");
  a_halt_run: assert property (@(posedge clk) disable iff (sys_rst)
    st.ledPwr[ncr_pkg::POS_POWERDOWN_ENABLE] && req.wrEn && req.addr == ncr_pkg::OFF_HALT_CLOCK &&
    req.wdata == ncr_pkg::HALT_RUNNING |=> ##1 powerdownClkRun) else $error("52h not honoured");
  a_halt_off: assert property (@(posedge clk) disable iff (sys_rst)
    !st.ledPwr[ncr_pkg::POS_POWERDOWN_ENABLE] |=> ##1 !powerdownClkRun && !powerdownClkHalt)
    else $error("power-down mode while bit clear");
  a_status_read: assert property (@(posedge clk) disable iff (sys_rst)
    req.rdEn && req.addr == ncr_pkg::OFF_CHIP_MEDIA |=> rdata[ncr_pkg::POS_JUMPER] == $past(jumperModeInput) &&
    rdata[ncr_pkg::POS_COAX] == $past(coaxFlag) && rdata[1:0] == 2'h0) else $error("status read wrong");
  a_inactive: assert property (@(posedge clk) disable iff (sys_rst)
    req.rdEn && req.addr == ncr_pkg::OFF_LED_POWER |=> rdata[0] == !$past(activateBit0))
    else $error("inactive flag wrong");
  a_irq_one: assert property (@(posedge clk) disable iff (sys_rst)
    $countones(~intOe_n) <= 1) else $error("more than one interrupt line driven");

  // writable bits land exactly as written while config mode is open
  a_irqio_write: assert property (@(posedge clk) disable iff (sys_rst)
    req.wrEn && cfgMode && !eepromLoad && req.addr == ncr_pkg::OFF_IRQ_IOBASE
    |=> st.irqIo[7] == $past(req.wdata[7])) else $error("irq enable write lost");
  a_medboot_write: assert property (@(posedge clk) disable iff (sys_rst)
    req.wrEn && cfgMode && !eepromLoad && req.addr == ncr_pkg::OFF_MEDIUM_BOOT
    |=> st.medBoot[7:5] == $past(req.wdata[7:5])) else $error("medium/boot write lost");
  a_sleep_write: assert property (@(posedge clk) disable iff (sys_rst)
    req.wrEn && cfgMode && !eepromLoad && req.addr == ncr_pkg::OFF_LED_POWER
    |=> st.ledPwr[ncr_pkg::POS_SLEEP] == $past(req.wdata[ncr_pkg::POS_SLEEP])) else $error("sleep write lost");
  a_version_write: assert property (@(posedge clk) disable iff (sys_rst)
    VARIANT == ncr_pkg::NCR_VER_WRITABLE && req.wrEn && cfgMode && req.addr == ncr_pkg::OFF_CHIP_MEDIA
    |=> st.version == $past(req.wdata[7:6])) else $error("version write lost");
  a_version_fixed: assert property (@(posedge clk) disable iff (sys_rst)
    VARIANT != ncr_pkg::NCR_VER_WRITABLE |=> $stable(st.version)) else $error("fixed version changed");

  // eeprom image is taken whole, host write or not
  a_load_irqio: assert property (@(posedge clk) disable iff (sys_rst)
    eepromLoad |=> st.irqIo == $past(eepromIrqIo)) else $error("irq/io load lost");
  a_load_medboot: assert property (@(posedge clk) disable iff (sys_rst)
    eepromLoad |=> st.medBoot == $past(eepromMedBoot)) else $error("medium/boot load lost");
  a_load_ledpwr: assert property (@(posedge clk) disable iff (sys_rst)
    eepromLoad |=> st.ledPwr == $past(eepromLedPwr)) else $error("led/power load lost");

  // halt clock decoding; only two codes act and only while powered down
  a_halt_clk: assert property (@(posedge clk) disable iff (sys_rst)
    st.ledPwr[ncr_pkg::POS_POWERDOWN_ENABLE] && req.wrEn && req.addr == ncr_pkg::OFF_HALT_CLOCK &&
    req.wdata == ncr_pkg::HALT_HALTED |=> ##1 powerdownClkHalt) else $error("48h not honoured");
  a_halt_other: assert property (@(posedge clk) disable iff (sys_rst)
    st.ledPwr[ncr_pkg::POS_POWERDOWN_ENABLE] && req.wrEn && req.addr == ncr_pkg::OFF_HALT_CLOCK &&
    req.wdata != ncr_pkg::HALT_RUNNING && req.wdata != ncr_pkg::HALT_HALTED
    |=> $stable(st.pdMode)) else $error("other halt value acted");
  a_halt_idle: assert property (@(posedge clk) disable iff (sys_rst)
    st.ledPwr[ncr_pkg::POS_POWERDOWN_ENABLE] && !(req.wrEn && req.addr == ncr_pkg::OFF_HALT_CLOCK)
    |=> $stable(st.pdMode)) else $error("power-down mode changed without write");
  a_pd_none: assert property (@(posedge clk) disable iff (sys_rst)
    !st.ledPwr[ncr_pkg::POS_POWERDOWN_ENABLE] |=> st.pdMode == ncr_pkg::NCR_PD_NONE)
    else $error("power-down mode kept with bit clear");
  a_halt_excl: assert property (@(posedge clk) disable iff (sys_rst)
    !(powerdownClkRun && powerdownClkHalt)) else $error("both power-down modes active");
  a_sleep_out: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> sleepMode == $past(st.ledPwr[ncr_pkg::POS_SLEEP])) else $error("sleep output wrong");

  // interrupt steering, one flop behind the stored select
  a_int_out_reg: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> intOut == $past(routeOut)) else $error("interrupt output not registered");
  a_int_oe_reg: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> intOe_n == $past(routeOe_n)) else $error("interrupt enable not registered");
  a_irq_off: assert property (@(posedge clk) disable iff (sys_rst)
    !st.irqIo[ncr_pkg::POS_INTERRUPT_OUTPUT_ENABLE] |=> intOe_n == 8'hff) else $error("line driven while disabled");
  a_irq_sel: assert property (@(posedge clk) disable iff (sys_rst)
    st.irqIo[ncr_pkg::POS_INTERRUPT_OUTPUT_ENABLE] |=> intOe_n == ~(8'h01 << $past(st.irqIo[6:4])))
    else $error("wrong interrupt line enabled");
  a_irq_value: assert property (@(posedge clk) disable iff (sys_rst)
    st.irqIo[ncr_pkg::POS_INTERRUPT_OUTPUT_ENABLE] && irqReq |=> intOut == (8'h01 << $past(st.irqIo[6:4])))
    else $error("interrupt level not steered");

  // read path: registered, zero when idle or unmapped
  a_rd_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !req.rdEn |=> rdata == 8'h00) else $error("read data not cleared");
  a_rd_irqio: assert property (@(posedge clk) disable iff (sys_rst)
    req.rdEn && req.addr == ncr_pkg::OFF_IRQ_IOBASE |=> rdata == $past(st.irqIo))
    else $error("irq/io read wrong");
  a_rd_medboot: assert property (@(posedge clk) disable iff (sys_rst)
    req.rdEn && req.addr == ncr_pkg::OFF_MEDIUM_BOOT |=> rdata == $past(st.medBoot))
    else $error("medium/boot read wrong");
  a_rd_ledpwr: assert property (@(posedge clk) disable iff (sys_rst)
    req.rdEn && req.addr == ncr_pkg::OFF_LED_POWER |=> rdata[7:1] == $past(st.ledPwr[7:1]))
    else $error("led/power read wrong");
  a_status_ver: assert property (@(posedge clk) disable iff (sys_rst)
    req.rdEn && req.addr == ncr_pkg::OFF_CHIP_MEDIA |=> rdata[7:6] == $past(st.version))
    else $error("version read wrong");
  a_status_pins: assert property (@(posedge clk) disable iff (sys_rst)
    req.rdEn && req.addr == ncr_pkg::OFF_CHIP_MEDIA
    |=> rdata[5] == $past(attachmentUnitIn) && rdata[4] == $past(pnpJumperPin)) else $error("pin status wrong");
  a_rd_unmapped: assert property (@(posedge clk) disable iff (sys_rst)
    req.rdEn && (req.addr < ncr_pkg::OFF_CHIP_MEDIA || req.addr > ncr_pkg::OFF_LED_POWER)
    |=> rdata == 8'h00) else $error("unmapped read not zero");

  // coax flag against the medium select field
  a_coax_auto: assert property (@(posedge clk) disable iff (sys_rst)
    st.medBoot[7:6] == ncr_pkg::MEDIUM_AUTO && linkTestFail |-> coaxFlag) else $error("auto coax missing");
  a_coax_sel: assert property (@(posedge clk) disable iff (sys_rst)
    st.medBoot[7:6] == ncr_pkg::MEDIUM_COAX |-> coaxFlag) else $error("selected coax missing");
  a_coax_off: assert property (@(posedge clk) disable iff (sys_rst)
    st.medBoot[7:6] != ncr_pkg::MEDIUM_COAX && !(st.medBoot[7:6] == ncr_pkg::MEDIUM_AUTO && linkTestFail)
    |-> !coaxFlag) else $error("coax flag spurious");

  c_cfg_write: cover property (@(posedge clk) req.wrEn && cfgMode && req.addr == ncr_pkg::OFF_LED_POWER);
  c_clk_run: cover property (@(posedge clk) powerdownClkRun);
  c_eeprom_load: cover property (@(posedge clk) eepromLoad && st.ledPwr[ncr_pkg::POS_POWERDOWN_ENABLE]);
  c_halt: cover property (@(posedge clk) powerdownClkHalt);
  c_irq: cover property (@(posedge clk) !intOe_n[5] && intOut[5]);
endmodule : ncr_config_bank
`default_nettype wire

// ===== hw/ncr_irq_route.sv
// steers the interrupt request onto one of eight open outputs
`timescale 1ns/1ps
`default_nettype none
module ncr_irq_route (
  input wire logic irqReq,
  input wire logic enable,
  input wire logic [2:0] lineSel,
  output logic [7:0] intOut,
  output logic [7:0] intOe_n
);
  always_comb begin
    intOut = 8'h00;
    intOe_n = 8'hff;
    if (enable) begin
      intOut[lineSel] = irqReq;
      intOe_n[lineSel] = 1'b0;
    end
  end
endmodule : ncr_irq_route
`default_nettype wire

// ===== hw/ncr_masked_reg.sv
// next-value logic for a byte register whose writable bits are given by a mask and gated by a write enable
`timescale 1ns/1ps
`default_nettype none
module ncr_masked_reg #(
  parameter logic [7:0] MASK = 8'hff
) (
  input wire logic [7:0] cur,
  input wire logic [7:0] wdata,
  input wire logic we,
  output logic [7:0] nxt
);
  // read-only bits and disabled writes keep the stored value
  assign nxt = we ? ((cur & ~MASK) | (wdata & MASK)) : cur;
endmodule : ncr_masked_reg
`default_nettype wire

// ===== hw/ncr_pkg.sv
// package: offsets, field positions, reset values and types of the configuration register bank
package ncr_pkg;
  localparam logic [3:0] OFF_CHIP_MEDIA = 4'h3;
  localparam logic [3:0] OFF_IRQ_IOBASE = 4'h4;
  localparam logic [3:0] OFF_MEDIUM_BOOT = 4'h5;
  localparam logic [3:0] OFF_LED_POWER = 4'h6;
  localparam logic [3:0] OFF_HALT_CLOCK = 4'h9;
  localparam logic [1:0] EEM_CFG_WRITE = 2'h3;
  localparam logic [7:0] HALT_RUNNING = 8'h52;
  localparam logic [7:0] HALT_HALTED = 8'h48;
  localparam int POS_VERSION = 6;
  localparam int POS_ATTACH = 5;
  localparam int POS_PNP_JUMPER_FLAG = 4;
  localparam int POS_JUMPER = 3;
  localparam int POS_COAX = 2;
  localparam int POS_INTERRUPT_OUTPUT_ENABLE = 7;
  localparam int POS_SLEEP = 2;
  localparam int POS_POWERDOWN_ENABLE = 1;
  localparam logic [1:0] VERSION_RESET = 2'h0;
  localparam logic [7:0] MASK_IRQ_IOBASE = 8'h80;
  localparam logic [7:0] MASK_MEDIUM_BOOT = 8'he0;
  localparam logic [7:0] MASK_LED_POWER = 8'h06;
  localparam logic [7:0] IRQ_IOBASE_RESET = 8'h80;
  localparam logic [7:0] MEDIUM_BOOT_RESET = 8'h00;
  localparam logic [7:0] LED_POWER_RESET = 8'h01;
  localparam logic [1:0] MEDIUM_AUTO = 2'h0;
  localparam logic [1:0] MEDIUM_COAX = 2'h3;

  // version field behaviour per chip variant
  typedef enum logic [1:0] {
    NCR_VER_FIXED_11 = 2'h0,
    NCR_VER_FIXED_10 = 2'h1,
    NCR_VER_WRITABLE = 2'h2
  } ncr_variant_t;

  typedef enum logic [2:0] {
    NCR_PD_NONE = 3'b001,
    NCR_PD_CLK_RUN = 3'b010,
    NCR_PD_CLK_HALT = 3'b100
  } ncr_pdmode_t;

  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ncr_req_t;

  typedef struct packed {
    logic [1:0] version;
    logic [7:0] irqIo;
    logic [7:0] medBoot;
    logic [7:0] ledPwr;
    ncr_pdmode_t pdMode;
    logic [7:0] rdata;
  } ncr_state_t;
endpackage : ncr_pkg
